/* File: sar_adc_pkg.sv */
// Package with register map, field layout and types of the converter control block.
package sar_adc_pkg;
	localparam int RESULT_W = 11;
	localparam int ACC_W = 14;
	localparam logic [7:0] CONFIG_IDX = 8'ha9;
	localparam logic [7:0] RESULT_LOW_IDX = 8'hba;
	localparam logic [7:0] RESULT_HIGH_IDX = 8'hbb;
	localparam logic [7:0] CONTROL_IDX = 8'hce;
	localparam logic [7:0] STATUS_IDX = 8'hcf;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int CFG_POWER_BIT = 7;
	localparam int CFG_IRQEN_BIT = 6;
	localparam int CFG_JUSTIFY_BIT = 5;
	localparam int CFG_DIV_LSB = 0;
	localparam int CTL_AVG_LSB = 6;
	localparam int CTL_SEL_LSB = 4;
	localparam int CTL_START_BIT = 0;
	localparam int STS_DONE_BIT = 0;
	localparam int SETTLE_TIME_NS = 20000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SEL_INPUT_A = 2'h0;
	localparam logic [1:0] SEL_INPUT_B = 2'h1;
	localparam logic [1:0] SEL_TEMPERATURE = 2'h2;
	localparam logic [1:0] SEL_SUPPLY_FIFTH = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_WAIT = 2'b10,
		ST_FINISH = 2'b11
	} conv_state_e;

	typedef struct packed {
		logic powerOn;
		logic [1:0] inputSelect;
		logic sampleStart;
		logic convClk;
	} core_ctrl_s;

	typedef struct packed {
		logic sampleDone;
		logic [RESULT_W-1:0] sampleData;
	} core_result_s;
endpackage : sar_adc_pkg

/* File: sar_adc_control.sv */
// Register file, prescaler, averaging sequencer and result path of the converter control.
`timescale 1ns/10ps
// Functional notes
// - Eleven-bit result, four selectable inputs.
// - Power bit enables converter, clear powers down.
// - Done interrupt only when enable bit set.
// - Left justify: high eight bits, low top three.
// - Right justify: high low three, low eight.
// - Divide field gives clock divided 2 to 256.
// - Averaging field 1,2,4,8 samples, resets 00.
// - Select field change applies at once, even mid-average.
// - Select field routes A, B, temperature, supply fifth.
// - Done flag set in the same cycle as both bytes are written.
// - Reading low byte clears done flag.
// - No result update while done flag set, unless the low byte is read in that cycle.
// - Writing start bit begins a conversion.
// - Start bit stays high, clears when done.
// - Result bytes are read-only.
module sar_adc_control
	import sar_adc_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic convIrq,
	output core_ctrl_s coreCtrl,
	input wire core_result_s coreResult
);
	initial begin
		if (ADDR_W < 10) begin
			$error("ADDR_W must be at least 10 to reach the register map.");
		end
	end

	logic [7:0] configReg;
	logic [7:0] next_configReg;
	logic [1:0] averageCount;
	logic [1:0] next_averageCount;
	logic [1:0] inputSelect;
	logic [1:0] next_inputSelect;
	logic swConvertTrigger;
	logic next_swConvertTrigger;
	logic conversionDoneFlag;
	logic next_conversionDoneFlag;
	logic [7:0] resultLowByte;
	logic [7:0] next_resultLowByte;
	logic [7:0] resultHighByte;
	logic [7:0] next_resultHighByte;
	logic busAck;
	logic next_busAck;
	logic [31:0] next_readdata;
	conv_state_e state;
	conv_state_e next_state;
	logic [ACC_W-1:0] accum;
	logic [ACC_W-1:0] next_accum;
	logic [3:0] samplesLeft;
	logic [3:0] next_samplesLeft;
	logic [1:0] avgLatched;
	logic [1:0] next_avgLatched;
	logic [7:0] divCount;
	logic [7:0] next_divCount;
	logic convClk;
	logic next_convClk;
	logic sampleStart;
	logic next_sampleStart;

	logic accessDone;
	logic writeDone;
	logic readDone;
	logic [7:0] wordIdx;
	logic idxAligned;
	logic powerOn;
	logic [7:0] divLimit;
	logic [RESULT_W-1:0] mean;
	logic finishing;

	assign wordIdx = address[9:2];
	assign idxAligned = (address[1:0] == 2'h0) && (address[ADDR_W-1:2] == (ADDR_W-2)'(wordIdx));
	assign accessDone = (read || write) && busAck;
	assign writeDone = write && busAck && byteenable[0] && idxAligned;
	assign readDone = read && busAck && idxAligned;
	assign waitrequest = (read || write) && !busAck;
	assign powerOn = configReg[CFG_POWER_BIT];
	assign divLimit = 8'((9'h001 << configReg[CFG_DIV_LSB +: 3]) - 9'h001);
	assign mean = RESULT_W'(accum >> avgLatched);
	assign finishing = (state == ST_FINISH);

	always_comb begin
		coreCtrl.powerOn = powerOn;
		coreCtrl.inputSelect = inputSelect;
		coreCtrl.sampleStart = sampleStart;
		coreCtrl.convClk = convClk;
		convIrq = conversionDoneFlag && configReg[CFG_IRQEN_BIT];
	end

	always_comb begin
		next_busAck = (read || write) && !busAck;
		next_readdata = readdata;
		next_configReg = configReg;
		next_averageCount = averageCount;
		next_inputSelect = inputSelect;
		if (read && !busAck) begin
			next_readdata = 32'h0000_0000;
			if (address[1:0] == 2'h0) begin
				case (wordIdx)
					CONFIG_IDX: next_readdata[7:0] = configReg;
					RESULT_LOW_IDX: next_readdata[7:0] = resultLowByte;
					RESULT_HIGH_IDX: next_readdata[7:0] = resultHighByte;
					CONTROL_IDX: begin
						next_readdata[CTL_AVG_LSB +: 2] = averageCount;
						next_readdata[CTL_SEL_LSB +: 2] = inputSelect;
						next_readdata[CTL_START_BIT] = swConvertTrigger;
					end
					STATUS_IDX: next_readdata[STS_DONE_BIT] = conversionDoneFlag;
					default: next_readdata = 32'h0000_0000;
				endcase
			end
		end
		if (writeDone && wordIdx == CONFIG_IDX) begin
			next_configReg = writedata[7:0] & 8'he7;
		end
		if (writeDone && wordIdx == CONTROL_IDX) begin
			next_averageCount = writedata[CTL_AVG_LSB +: 2];
			next_inputSelect = writedata[CTL_SEL_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			busAck <= 1'b0;
			readdata <= 32'h0000_0000;
			configReg <= CONFIG_RESET;
			averageCount <= CONTROL_RESET[CTL_AVG_LSB +: 2];
			inputSelect <= CONTROL_RESET[CTL_SEL_LSB +: 2];
		end else begin
			busAck <= next_busAck;
			readdata <= next_readdata;
			configReg <= next_configReg;
			averageCount <= next_averageCount;
			inputSelect <= next_inputSelect;
		end
	end

	always_comb begin
		next_divCount = divCount + 8'h01;
		next_convClk = convClk;
		if (!powerOn) begin
			next_divCount = 8'h00;
			next_convClk = 1'b0;
		end else if (divCount >= divLimit) begin
			next_divCount = 8'h00;
			next_convClk = !convClk;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			divCount <= 8'h00;
			convClk <= 1'b0;
		end else begin
			divCount <= next_divCount;
			convClk <= next_convClk;
		end
	end

	always_comb begin
		next_state = state;
		next_accum = accum;
		next_samplesLeft = samplesLeft;
		next_avgLatched = avgLatched;
		next_sampleStart = 1'b0;
		next_swConvertTrigger = swConvertTrigger;
		next_conversionDoneFlag = conversionDoneFlag;
		next_resultLowByte = resultLowByte;
		next_resultHighByte = resultHighByte;
		if (readDone && wordIdx == RESULT_LOW_IDX) begin
			next_conversionDoneFlag = 1'b0;
		end
		case (state)
			ST_IDLE: begin
				if (writeDone && wordIdx == CONTROL_IDX && writedata[CTL_START_BIT]) begin
					if (powerOn) begin
						next_swConvertTrigger = 1'b1;
						next_avgLatched = writedata[CTL_AVG_LSB +: 2];
						next_samplesLeft = 4'(4'h1 << writedata[CTL_AVG_LSB +: 2]);
						next_accum = '0;
						next_state = ST_SAMPLE;
					end
				end
			end
			ST_SAMPLE: begin
				next_sampleStart = 1'b1;
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (coreResult.sampleDone) begin
					next_accum = accum + ACC_W'(coreResult.sampleData);
					next_samplesLeft = samplesLeft - 4'h1;
					if (samplesLeft == 4'h1) begin
						next_state = ST_FINISH;
					end else begin
						next_state = ST_SAMPLE;
					end
				end
			end
			ST_FINISH: begin
				next_swConvertTrigger = 1'b0;
				next_state = ST_IDLE;
				if (!conversionDoneFlag || (readDone && wordIdx == RESULT_LOW_IDX)) begin
					if (configReg[CFG_JUSTIFY_BIT]) begin
						next_resultHighByte = mean[10:3];
						next_resultLowByte = {mean[2:0], 5'h00};
					end else begin
						next_resultHighByte = {5'h00, mean[10:8]};
						next_resultLowByte = mean[7:0];
					end
					next_conversionDoneFlag = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (!powerOn && state != ST_IDLE) begin
			next_state = ST_IDLE;
			next_swConvertTrigger = 1'b0;
			next_sampleStart = 1'b0;
			next_conversionDoneFlag = conversionDoneFlag && !(readDone && wordIdx == RESULT_LOW_IDX);
			next_resultLowByte = resultLowByte;
			next_resultHighByte = resultHighByte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			accum <= '0;
			samplesLeft <= 4'h0;
			avgLatched <= 2'h0;
			sampleStart <= 1'b0;
			swConvertTrigger <= CONTROL_RESET[CTL_START_BIT];
			conversionDoneFlag <= 1'b0;
			resultLowByte <= 8'h00;
			resultHighByte <= 8'h00;
		end else begin
			state <= next_state;
			accum <= next_accum;
			samplesLeft <= next_samplesLeft;
			avgLatched <= next_avgLatched;
			sampleStart <= next_sampleStart;
			swConvertTrigger <= next_swConvertTrigger;
			conversionDoneFlag <= next_conversionDoneFlag;
			resultLowByte <= next_resultLowByte;
			resultHighByte <= next_resultHighByte;
		end
	end
endmodule : sar_adc_control

/* File: sar_adc_core_model.sv */
// Behavioural model of the analog converter core and its input switch.
`timescale 1ns/10ps
module sar_adc_core_model
	import sar_adc_pkg::*;
(
	input wire logic core_clk,
	input wire core_ctrl_s coreCtrl,
	input wire logic [10:0] base,
	output core_result_s coreResult
);
	logic [3:0] cnt;
	logic busy = 1'b0;
	logic phase = 1'b0;
	initial coreResult = '0;
	always @(posedge core_clk) begin
		coreResult.sampleDone <= 1'b0;
		coreResult.sampleData <= ~coreResult.sampleData;
		if (coreCtrl.sampleStart) begin
			busy <= 1'b1;
			cnt <= {1'b0, base[2:0]};
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			phase <= !phase;
			coreResult <= {1'b1, base + {3'h0, coreCtrl.inputSelect, 6'h00} + {9'h0, phase, 1'b0}};
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule : sar_adc_core_model

/* File: sar_adc_control_properties.sv */
// Port checker of the converter control.
`timescale 1ns/10ps
module sar_adc_control_properties
	import sar_adc_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic convIrq,
	input wire core_ctrl_s coreCtrl,
	input wire core_result_s coreResult
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic done;
	assign done = !waitrequest && (read || write);
	wait_once_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("wait too long");
	read_upper_a: assert property (done && read |-> readdata[31:8] == 24'h0)
		else $error("upper bits set");
	start_pulse_a: assert property (coreCtrl.sampleStart |=> !coreCtrl.sampleStart)
		else $error("start too long");
	off_clk_a: assert property (!coreCtrl.powerOn |=> !coreCtrl.convClk)
		else $error("clock while off");
	off_start_a: assert property (!coreCtrl.powerOn && !$past(coreCtrl.powerOn) |-> !coreCtrl.sampleStart)
		else $error("start while off");
	irq_mask_a: assert property (done && write && address == {CONFIG_IDX, 2'b00} && byteenable[0]
		&& !writedata[CFG_IRQEN_BIT] |=> !convIrq)
		else $error("irq not masked");
	low_clear_a: assert property (done && read && address == {RESULT_LOW_IDX, 2'b00}
		|=> !convIrq || $past(coreResult.sampleDone, 2))
		else $error("flag not cleared");
	irq_cause_a: assert property ($rose(convIrq) |-> $past(coreResult.sampleDone, 2) || $past(done))
		else $error("irq without cause");
	cover property ($rose(convIrq));
	cover property (coreCtrl.sampleStart);
	cover property (done && read && address == {RESULT_LOW_IDX, 2'b00});
endmodule : sar_adc_control_properties
bind sar_adc_control sar_adc_control_properties #(.ADDR_W(ADDR_W)) checker_inst (.core_clk, .nrst,
	.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .convIrq, .coreCtrl,
	.coreResult);

/* File: sar_adc_control_test.sv */
// Self-checking bench of the converter control.
`timescale 1ns/10ps
module sar_adc_control_test
	import sar_adc_pkg::*;
;
	logic core_clk, nrst, read, write, waitrequest, convIrq, par, j, ie;
	logic [9:0] address;
	logic [31:0] writedata, readdata, seed;
	logic [7:0] rd;
	logic [10:0] base;
	logic [1:0] a, s;
	logic [15:0] res, nx;
	int failures, n_checks, p, k, t1, t2;
	core_ctrl_s coreCtrl;
	core_result_s coreResult;
	logic [7:0] ix [6] = '{CONFIG_IDX, CONTROL_IDX, RESULT_LOW_IDX, RESULT_HIGH_IDX, STATUS_IDX, 8'h10};
	sar_adc_control uut (.core_clk, .nrst, .address, .read, .write, .writedata, .byteenable(4'h1),
		.readdata, .waitrequest, .convIrq, .coreCtrl, .coreResult);
	sar_adc_core_model core (.core_clk, .coreCtrl, .base, .coreResult);
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(logic wr, logic [7:0] idx, logic [7:0] wd);
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		writedata <= {24'h0, wd};
		@(posedge core_clk);
		for (k = 0; k < 20 && waitrequest !== 1'b0; k++) begin
			@(posedge core_clk);
		end
		chk("bus wait", waitrequest, 1'b0);
		if (k == 20) begin
			end_of_test();
		end
		rd = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [15:0] want(logic [10:0] b);
		logic [10:0] m;
		m = b + {3'h0, s, 6'h00} + ((a == 2'h0) ? {9'h0, par, 1'b0} : 11'h1);
		return j ? {m[10:3], m[2:0], 5'h00} : {5'h00, m};
	endfunction : want
	task automatic conv();
		seed = lfsr(seed);
		base <= {1'b0, seed[9:0]};
		nx = want({1'b0, seed[9:0]});
		par = par ^ (a == 2'h0);
		bus(1'b1, CONTROL_IDX, {a, s, 4'h1});
		bus(1'b0, CONTROL_IDX, 8'h00);
		chk("control busy", rd, {a, s, 4'h1});
		for (t1 = 0; t1 < 99 && rd[0] !== 1'b0; t1++) begin
			bus(1'b0, CONTROL_IDX, 8'h00);
		end
		chk("control idle", rd, {a, s, 4'h0});
		if (t1 == 99) begin
			end_of_test();
		end
	endtask : conv
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		base = '0;
		seed = 32'h00016077;
		par = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		bus(1'b1, RESULT_LOW_IDX, 8'hff);
		bus(1'b1, RESULT_HIGH_IDX, 8'hff);
		bus(1'b1, CONTROL_IDX, 8'h01);
		foreach (ix[i]) begin
			bus(1'b0, ix[i], 8'h00);
			chk("reset read", rd, 8'h00);
		end
		$display("reset done");
		for (p = 0; p < 8; p++) begin
			bus(1'b1, CONFIG_IDX, {5'h10, p[2:0]});
			for (t1 = 0; t1 < 1100; t1++) begin
				@(negedge core_clk);
				if (coreCtrl.convClk && !j) begin
					k = t2;
					t2 = t1;
				end
				j = coreCtrl.convClk;
			end
			@(posedge core_clk);
			chk("clock period", 16'(t2 - k), 16'(2 << p));
		end
		$display("divider done");
		for (p = 0; p < 16; p++) begin
			a = p[1:0];
			s = p[3:2];
			j = seed[4];
			ie = seed[5];
			bus(1'b1, CONFIG_IDX, {1'b1, ie, j, 5'h00});
			conv();
			res = nx;
			if (seed[2] || p == 5) begin
				conv();
			end
			bus(1'b0, STATUS_IDX, 8'h00);
			chk("done flag", rd, 8'h01);
			chk("irq", convIrq, ie);
			bus(1'b0, RESULT_HIGH_IDX, 8'h00);
			chk("high byte", rd, res[15:8]);
			bus(1'b0, RESULT_LOW_IDX, 8'h00);
			chk("low byte", rd, res[7:0]);
			bus(1'b0, STATUS_IDX, 8'h00);
			chk("flag clear", rd, 8'h00);
		end
		$display("conversions done");
		bus(1'b1, CONFIG_IDX, 8'h80);
		bus(1'b1, CONTROL_IDX, 8'hc1);
		bus(1'b1, CONFIG_IDX, 8'h00);
		bus(1'b0, CONTROL_IDX, 8'h00);
		chk("abort start", rd, 8'hc0);
		repeat (200) @(posedge core_clk);
		bus(1'b0, STATUS_IDX, 8'h00);
		chk("abort flag", rd, 8'h00);
		bus(1'b1, CONFIG_IDX, 8'h80);
		repeat (SETTLE_CYCLES) @(posedge core_clk);
		a = 2'h1;
		s = 2'h2;
		j = 1'b0;
		conv();
		bus(1'b0, RESULT_HIGH_IDX, 8'h00);
		chk("resume high", rd, nx[15:8]);
		bus(1'b0, RESULT_LOW_IDX, 8'h00);
		chk("resume low", rd, nx[7:0]);
		$display("abort done");
		end_of_test();
	end
endmodule : sar_adc_control_test
